// ===== logic/rcer_defines.vh
// Constants of the remote command error reporter: register map, fields, codes.
// Assumes inclusion by bare name in rcer_top and in the bench files only.
`ifndef RCER_DEFINES_VH
`define RCER_DEFINES_VH

`define RCER_OFS_CTRL 8'h00
`define RCER_OFS_STAT 8'h04
`define RCER_OFS_ESR 8'h08
`define RCER_OFS_ERRQ 8'h0c
`define RCER_OFS_CMD 8'h10
`define RCER_OFS_INTV 8'h14
`define RCER_OFS_LVL 8'h18

`define RCER_CTRL_ECHO 0
`define RCER_CTRL_EXT 1
`define RCER_CTRL_DFILT 2
`define RCER_CTRL_DSRUN 3
`define RCER_CTRL_UNIT_LSB 4
`define RCER_CTRL_UNIT_MSB 5

`define RCER_UNIT_WATT 2'h0
`define RCER_UNIT_DBM 2'h1

`define RCER_CMD_STORE 0
`define RCER_CMD_STATS 1

`define RCER_ESR_DEV 3
`define RCER_ESR_EXE 4
`define RCER_ESR_CMD 5

`define RCER_ERRQ_VALID 16

`define RCER_KIND_NUMTYPE 3'h0
`define RCER_KIND_DIGEXP 3'h1
`define RCER_KIND_DIGUNEXP 3'h2
`define RCER_KIND_IDENT 3'h3
`define RCER_KIND_SYNTAX 3'h4
`define RCER_KIND_ARGS 3'h5

`define RCER_CODE_W 10
`define RCER_E104 10'h068
`define RCER_E106 10'h06a
`define RCER_E107 10'h06b
`define RCER_E115 10'h073
`define RCER_E116 10'h074
`define RCER_E126 10'h07e
`define RCER_E201 10'h0c9
`define RCER_E214 10'h0d6
`define RCER_E301 10'h12d
`define RCER_E303 10'h12f
`define RCER_E304 10'h130
`define RCER_E305 10'h131
`define RCER_E704 10'h2c0
`define RCER_E705 10'h2c1
`define RCER_E706 10'h2c2
`define RCER_E707 10'h2c3
`define RCER_E708 10'h2c4
`define RCER_E709 10'h2c5

`define RCER_RX_DEPTH 1024
`define RCER_OUT_DEPTH 4096
`define RCER_PARSE_DEPTH 2048

`endif

// ===== logic/rcer_buf_track.v
// Occupancy tracker for one character buffer with overflow detection.
// Assumes the consumer never releases more characters than are held.
`default_nettype none
module rcer_buf_track #(
	parameter DEPTH = 1024,
	parameter LW = 11
) (
	input wire pclk,
	input wire presetn,
	input wire pce,
	input wire add,
	input wire [LW-1:0] add_amt,
	input wire sub,
	input wire [LW-1:0] sub_amt,
	output wire [LW-1:0] level,
	output wire ovf
);
	reg [LW-1:0] level_q;
	reg ovf_q;
	reg [LW-1:0] after_sub;
	reg [LW:0] with_add;

	always @*
	begin
		after_sub = level_q - (sub ? sub_amt : {LW{1'b0}});
		with_add = {1'b0, after_sub} + {1'b0, add_amt};
	end

	// An addition that does not fit is refused whole and flagged.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			level_q <= {LW{1'b0}};
			ovf_q <= 1'b0;
		end
		else if (pce)
		begin
			ovf_q <= add && (with_add > DEPTH);
			if (add && (with_add <= DEPTH))
				level_q <= with_add[LW-1:0];
			else
				level_q <= after_sub;
		end
	end

	assign level = level_q;
	assign ovf = ovf_q;
endmodule
`default_nettype wire

// ===== logic/rcer_err_queue.v
// First-in first-out store of error codes awaiting an error query.
// Ignores a pop asked while the queue holds no entry.
`default_nettype none
module rcer_err_queue #(
	parameter W = 10,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire pclk,
	input wire presetn,
	input wire pce,
	input wire push,
	input wire [W-1:0] din,
	input wire pop,
	output wire [W-1:0] dout,
	output wire [AW:0] count,
	output wire full
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire do_push;
	wire do_pop;

	assign do_pop = pop && (cnt_q != {(AW+1){1'b0}});
	assign do_push = push && ((cnt_q != DEPTH) || do_pop);

	always @(posedge pclk)
	begin
		if (pce && do_push)
			mem[wr_q] <= din;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else if (pce)
		begin
			if (do_push)
				wr_q <= wr_q + 1'b1;
			if (do_pop)
				rd_q <= rd_q + 1'b1;
			if (do_push && !do_pop)
				cnt_q <= cnt_q + 1'b1;
			else if (do_pop && !do_push)
				cnt_q <= cnt_q - 1'b1;
		end
	end

	assign dout = mem[rd_q];
	assign count = cnt_q;
	assign full = (cnt_q == DEPTH);
endmodule
`default_nettype wire

// ===== logic/rcer_top.v
// Error classification, event status and reporting for the remote command interpreter.
// Assumes fault inputs are one-cycle pulses synchronous to pclk, and an APB master.
`include "rcer_defines.vh"
`default_nettype none

// Functional notes
// - With echo on, the error code that wins each cycle is sent out one cycle later.
// - With echo off, errors are held until the host queries them.
// - Any parsing error sets event status bit 5.
// - Any execution error sets event status bit 4.
// - Undefined number type prefix logs code 104.
// - Non-digit where a digit is expected logs code 106.
// - Digit where another character is expected logs code 107.
// - Invalid or malformed parameter logs code 115.
// - Structural command fault logs code 116.
// - Wrong number of arguments logs code 126.
// - Parameter out of range or set logs code 201.
// - Command longer than the maximum logs code 214.
// - Leaving remote mode while transmitting logs code 301.
// - Receive buffer holds 1024 characters; overflow logs code 303.
// - Response buffer holds 4096 characters; overflow logs code 304.
// - Parse buffer holds 2048 characters; a command not fitting logs 305.
// - Data reading faults set the device bit but queue nothing.
// - Storing a reference in watt or dBm units is refused with 704.
// - Data store setting change clears its queue and logs 705.
// - Filter interval may not exceed store interval; violation logs 706.
// - External trigger forces the digital filter off; asking for both in one write logs 707.
// - Statistics update refused with 708 if no new data, 709 if running.
module rcer_top #(
	parameter QDEPTH = 16,
	parameter QAW = 4,
	parameter RX_DEPTH = `RCER_RX_DEPTH,
	parameter OUT_DEPTH = `RCER_OUT_DEPTH,
	parameter PARSE_DEPTH = `RCER_PARSE_DEPTH
) (
	input wire pclk,
	input wire presetn,
	input wire pce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire cmd_fault,
	input wire [2:0] cmd_fault_kind,
	input wire range_fault,
	input wire length_fault,
	input wire remote_mode,
	input wire tx_active,
	input wire rx_push,
	input wire rx_pop,
	input wire out_push,
	input wire out_pop,
	input wire parse_xfer,
	input wire [11:0] parse_xfer_len,
	input wire parse_done,
	input wire [11:0] parse_done_len,
	input wire data_read_fault,
	input wire ds_param_change,
	input wire ds_new_data,
	output wire echo_valid,
	output wire [9:0] echo_code,
	output wire dfilt_on,
	output wire ds_clear,
	output wire ref_store,
	output wire stats_go
);
	reg [31:0] prdata_q;
	reg pready_q;
	reg pslverr_q;
	reg echo_valid_q;
	reg [9:0] echo_code_q;
	reg ds_clear_q;
	reg ref_store_q;
	reg stats_go_q;
	reg echo_en_q;
	reg ext_trig_q;
	reg dfilt_q;
	reg ds_run_q;
	reg [1:0] units_q;
	reg [15:0] filt_intv_q;
	reg [15:0] ds_intv_q;
	reg [2:0] esr_q;
	reg ds_new_q;
	reg remote_q;
	reg lost_q;
	reg [31:0] rd_d;
	reg hit_d;
	reg err_any;
	reg [9:0] err_code;
	wire apb_acc;
	wire wr;
	wire rd;
	wire wr_ctrl;
	wire wr_intv;
	wire wr_cmd;
	wire wr_esr;
	wire rd_errq;
	wire [9:0] q_dout;
	wire [QAW:0] q_count;
	wire q_full;
	wire [10:0] rx_level;
	wire [12:0] out_level;
	wire [11:0] parse_level;
	wire rx_ovf;
	wire out_ovf;
	wire parse_ovf;
	wire e301;
	wire e704;
	wire e706;
	wire e707;
	wire e708;
	wire e709;
	wire exe_any;
	wire dev_any;

	// Maps a parser fault kind onto its error code.
	function [9:0] kind_code;
		input [2:0] kind;
		begin
			case (kind)
				`RCER_KIND_NUMTYPE: kind_code = `RCER_E104;
				`RCER_KIND_DIGEXP: kind_code = `RCER_E106;
				`RCER_KIND_DIGUNEXP: kind_code = `RCER_E107;
				`RCER_KIND_IDENT: kind_code = `RCER_E115;
				`RCER_KIND_ARGS: kind_code = `RCER_E126;
				default: kind_code = `RCER_E116;
			endcase
		end
	endfunction

	// Tells whether an access address names the given register.
	function is_reg;
		input [7:0] addr;
		input [7:0] ofs;
		begin
			is_reg = (addr == ofs);
		end
	endfunction

	assign apb_acc = psel && penable && pready_q;
	assign wr = apb_acc && pwrite && !pslverr_q;
	assign rd = apb_acc && !pwrite && !pslverr_q;
	assign wr_ctrl = wr && is_reg(paddr, `RCER_OFS_CTRL);
	assign wr_intv = wr && is_reg(paddr, `RCER_OFS_INTV);
	assign wr_cmd = wr && is_reg(paddr, `RCER_OFS_CMD);
	assign wr_esr = wr && is_reg(paddr, `RCER_OFS_ESR);
	assign rd_errq = rd && is_reg(paddr, `RCER_OFS_ERRQ);

	rcer_buf_track #(.DEPTH(RX_DEPTH), .LW(11)) u_rx_track (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.add(rx_push),
		.add_amt(11'h001),
		.sub(rx_pop),
		.sub_amt(11'h001),
		.level(rx_level),
		.ovf(rx_ovf)
	);

	rcer_buf_track #(.DEPTH(OUT_DEPTH), .LW(13)) u_out_track (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.add(out_push),
		.add_amt(13'h0001),
		.sub(out_pop),
		.sub_amt(13'h0001),
		.level(out_level),
		.ovf(out_ovf)
	);

	rcer_buf_track #(.DEPTH(PARSE_DEPTH), .LW(12)) u_parse_track (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.add(parse_xfer),
		.add_amt(parse_xfer_len),
		.sub(parse_done),
		.sub_amt(parse_done_len),
		.level(parse_level),
		.ovf(parse_ovf)
	);

	assign e301 = remote_q && !remote_mode && tx_active;
	assign e704 = wr_cmd && pwdata[`RCER_CMD_STORE] &&
		(units_q == `RCER_UNIT_WATT || units_q == `RCER_UNIT_DBM);
	assign e709 = wr_cmd && pwdata[`RCER_CMD_STATS] && ds_run_q;
	assign e708 = wr_cmd && pwdata[`RCER_CMD_STATS] && !ds_run_q && !ds_new_q;
	assign e706 = wr_intv && (pwdata[15:0] > pwdata[31:16]);
	assign e707 = wr_ctrl && pwdata[`RCER_CTRL_EXT] && pwdata[`RCER_CTRL_DFILT];
	assign exe_any = range_fault || length_fault || e301 || rx_ovf || out_ovf || parse_ovf;
	assign dev_any = e704 || ds_param_change || e706 || e707 || e708 || e709;

	// One code is reported per cycle; parser faults win over later stages.
	always @*
	begin
		err_any = 1'b1;
		err_code = `RCER_E116;
		if (cmd_fault)
			err_code = kind_code(cmd_fault_kind);
		else if (range_fault)
			err_code = `RCER_E201;
		else if (length_fault)
			err_code = `RCER_E214;
		else if (e301)
			err_code = `RCER_E301;
		else if (rx_ovf)
			err_code = `RCER_E303;
		else if (out_ovf)
			err_code = `RCER_E304;
		else if (parse_ovf)
			err_code = `RCER_E305;
		else if (e704)
			err_code = `RCER_E704;
		else if (ds_param_change)
			err_code = `RCER_E705;
		else if (e706)
			err_code = `RCER_E706;
		else if (e707)
			err_code = `RCER_E707;
		else if (e709)
			err_code = `RCER_E709;
		else if (e708)
			err_code = `RCER_E708;
		else
			err_any = 1'b0;
	end

	rcer_err_queue #(.W(`RCER_CODE_W), .DEPTH(QDEPTH), .AW(QAW)) u_queue (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.push(err_any && !echo_en_q),
		.din(err_code),
		.pop(rd_errq),
		.dout(q_dout),
		.count(q_count),
		.full(q_full)
	);

	// Read data is prepared in the setup phase and shown during the access phase.
	always @*
	begin
		rd_d = 32'h00000000;
		hit_d = 1'b1;
		if (is_reg(paddr, `RCER_OFS_CTRL))
		begin
			rd_d[`RCER_CTRL_ECHO] = echo_en_q;
			rd_d[`RCER_CTRL_EXT] = ext_trig_q;
			rd_d[`RCER_CTRL_DFILT] = dfilt_q;
			rd_d[`RCER_CTRL_DSRUN] = ds_run_q;
			rd_d[`RCER_CTRL_UNIT_MSB:`RCER_CTRL_UNIT_LSB] = units_q;
		end
		else if (is_reg(paddr, `RCER_OFS_STAT))
			rd_d = {21'h000000, ds_new_q, lost_q, q_full, {(7-QAW){1'b0}}, q_count};
		else if (is_reg(paddr, `RCER_OFS_ESR))
			rd_d = {26'h0000000, esr_q, 3'h0};
		else if (is_reg(paddr, `RCER_OFS_ERRQ))
		begin
			if (q_count != {(QAW+1){1'b0}})
				rd_d = {15'h0000, 1'b1, 6'h00, q_dout};
		end
		else if (is_reg(paddr, `RCER_OFS_CMD))
			rd_d = 32'h00000000;
		else if (is_reg(paddr, `RCER_OFS_INTV))
			rd_d = {ds_intv_q, filt_intv_q};
		else if (is_reg(paddr, `RCER_OFS_LVL))
			rd_d = {4'h0, parse_level, 5'h00, rx_level};
		else
			hit_d = 1'b0;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else if (pce)
		begin
			pready_q <= psel && !penable;
			if (psel && !penable)
			begin
				prdata_q <= pwrite ? 32'h00000000 : rd_d;
				pslverr_q <= !hit_d;
			end
			else
			begin
				prdata_q <= 32'h00000000;
				pslverr_q <= 1'b0;
			end
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			echo_en_q <= 1'b0;
			ext_trig_q <= 1'b0;
			dfilt_q <= 1'b0;
			ds_run_q <= 1'b0;
			units_q <= `RCER_UNIT_WATT;
			filt_intv_q <= 16'h0000;
			ds_intv_q <= 16'h0000;
			esr_q <= 3'h0;
			ds_new_q <= 1'b0;
			remote_q <= 1'b0;
			lost_q <= 1'b0;
			echo_valid_q <= 1'b0;
			echo_code_q <= 10'h000;
			ds_clear_q <= 1'b0;
			ref_store_q <= 1'b0;
			stats_go_q <= 1'b0;
		end
		else if (pce)
		begin
			remote_q <= remote_mode;
			if (wr_ctrl)
			begin
				echo_en_q <= pwdata[`RCER_CTRL_ECHO];
				ext_trig_q <= pwdata[`RCER_CTRL_EXT];
				dfilt_q <= pwdata[`RCER_CTRL_DFILT] && !pwdata[`RCER_CTRL_EXT];
				ds_run_q <= pwdata[`RCER_CTRL_DSRUN];
				units_q <= pwdata[`RCER_CTRL_UNIT_MSB:`RCER_CTRL_UNIT_LSB];
			end
			if (wr_intv && !e706)
			begin
				filt_intv_q <= pwdata[15:0];
				ds_intv_q <= pwdata[31:16];
			end
			ds_clear_q <= ds_param_change;
			ref_store_q <= wr_cmd && pwdata[`RCER_CMD_STORE] && !e704;
			stats_go_q <= wr_cmd && pwdata[`RCER_CMD_STATS] && !e708 && !e709;
			// New data wins over the clear made by an accepted statistics update.
			if (ds_new_data)
				ds_new_q <= 1'b1;
			else if (stats_go_q)
				ds_new_q <= 1'b0;
			// Status bits: hardware set wins over a write-one clear.
			esr_q[0] <= dev_any || data_read_fault ||
				(esr_q[0] && !(wr_esr && pwdata[`RCER_ESR_DEV]));
			esr_q[1] <= exe_any ||
				(esr_q[1] && !(wr_esr && pwdata[`RCER_ESR_EXE]));
			esr_q[2] <= cmd_fault ||
				(esr_q[2] && !(wr_esr && pwdata[`RCER_ESR_CMD]));
			echo_valid_q <= err_any && echo_en_q;
			if (err_any && echo_en_q)
				echo_code_q <= err_code;
			if (err_any && !echo_en_q && q_full && !rd_errq)
				lost_q <= 1'b1;
			else if (wr_esr && pwdata[0])
				lost_q <= 1'b0;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign echo_valid = echo_valid_q;
	assign echo_code = echo_code_q;
	assign dfilt_on = dfilt_q;
	assign ds_clear = ds_clear_q;
	assign ref_store = ref_store_q;
	assign stats_go = stats_go_q;
endmodule
`default_nettype wire

// ===== tb/rcer_properties.sv
// Port checker of the error reporter, bound into every rcer_top instance.
// Assumes echo mode is changed only by APB writes to CTRL; checks pause while pce is low.
`include "rcer_defines.vh"
`default_nettype none
module rcer_properties (
	input wire pclk,
	input wire presetn,
	input wire pce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire cmd_fault,
	input wire [2:0] cmd_fault_kind,
	input wire range_fault,
	input wire length_fault,
	input wire remote_mode,
	input wire tx_active,
	input wire data_read_fault,
	input wire ds_param_change,
	input wire echo_valid,
	input wire [9:0] echo_code,
	input wire dfilt_on,
	input wire ds_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	logic echo_q;
	logic wr0;
	logic [9:0] kc [8];
	assign kc = '{`RCER_E104, `RCER_E106, `RCER_E107, `RCER_E115,
		`RCER_E116, `RCER_E126, `RCER_E116, `RCER_E116};
	assign wr0 = psel && penable && pready && pwrite && paddr == `RCER_OFS_CTRL;
	// Mirrors the echo bit so that echo and queue paths can be told apart.
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			echo_q <= 1'b0;
		else if (wr0 && pce)
			echo_q <= pwdata[`RCER_CTRL_ECHO];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn || !pce);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	chk_apb_ready: assert property (s_setup |=> pready ##1 !pready)
		else $error("pready not high for one access cycle");
	chk_unmapped_err: assert property (s_access ##0 (paddr > `RCER_OFS_LVL) |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_echo_off_quiet: assert property (!echo_q |=> !echo_valid)
		else $error("echo sent while echo mode off");
	chk_cmd_code: assert property (echo_q && cmd_fault |=> echo_valid && echo_code == kc[$past(cmd_fault_kind)])
		else $error("wrong parser fault code");
	chk_range_code: assert property (echo_q && range_fault && !cmd_fault |=> echo_valid && echo_code == `RCER_E201)
		else $error("wrong range fault code");
	chk_length_code: assert property (echo_q && length_fault && !cmd_fault && !range_fault |=> echo_code == `RCER_E214 && echo_valid)
		else $error("wrong length fault code");
	chk_query_code: assert property (echo_q && $fell(remote_mode) && tx_active && !(cmd_fault || range_fault || length_fault) |=> echo_valid && echo_code == `RCER_E301)
		else $error("wrong query fault code");
	chk_read_quiet: assert property (data_read_fault && !psel && !(cmd_fault || range_fault || length_fault || ds_param_change) |=> !echo_valid)
		else $error("data read fault produced a code");
	chk_ds_clear: assert property (ds_param_change |=> ds_clear)
		else $error("data store not cleared");
	chk_ext_filter: assert property (wr0 && pwdata[`RCER_CTRL_EXT] |=> ##1 !dfilt_on)
		else $error("filter on with external trigger");
endmodule
bind rcer_top rcer_properties u_chk (.pclk, .presetn, .pce, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .cmd_fault, .cmd_fault_kind, .range_fault,
	.length_fault, .remote_mode, .tx_active, .data_read_fault, .ds_param_change,
	.echo_valid, .echo_code, .dfilt_on, .ds_clear);
`default_nettype wire

// ===== tb/rcer_host.sv
// Host side APB master model that carries every register access of the bench.
// Assumes one caller at a time and a slave that answers through pready.
`default_nettype none
module rcer_host (
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel = 1'b0,
	output logic penable = 1'b0,
	output logic pwrite = 1'b0,
	output logic [7:0] paddr = 8'h0,
	output logic [31:0] pwdata = 32'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	// The request is held until pready is sampled high or eight cycles pass; released data is inverted.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic ok);
		ok = 1'b0;
		r = 32'h0;
		e = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 8 && !ok; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
			begin
				r = prdata;
				e = pslverr;
				ok = 1'b1;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ===== tb/test_rcer_top.sv
// Self-checking bench of rcer_top with a host model and a queue model of codes.
// Assumes the checker binds itself and the buffer depths are shortened.
`include "rcer_defines.vh"
`default_nettype none
module test_rcer_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, e, ok;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [9:0] f = 10'h0;
	logic [2:0] kind = 3'h0;
	logic tx = 1'b1;
	logic ce = 1'b1;
	logic [2:0] g = 3'h0;
	logic [11:0] pl = 12'h0;
	logic [15:0] s;
	logic echo_valid, dfilt_on, ds_clear, ref_store, stats_go;
	logic [9:0] echo_code;
	logic [3:0] outs;
	int fails = 0;
	int n_tests = 0;
	int q[$];
	bit ech = 1'b0;
	int kc[8] = '{`RCER_E104, `RCER_E106, `RCER_E107, `RCER_E115,
		`RCER_E116, `RCER_E126, `RCER_E116, `RCER_E116};
	int cw[8] = '{32'h01, 32'h11, 32'h21, 32'h31, 32'h39, 32'h31, 32'h31, 32'h31};
	int cc[8] = '{1, 1, 1, 1, 2, 2, 2, 2};
	int cb[8] = '{0, 0, 2, 2, 0, 0, 3, 0};
	int cx[8] = '{`RCER_E704, `RCER_E704, 0, 0, `RCER_E709, `RCER_E708, 0, `RCER_E708};
	always #12.5 pclk = ~pclk;
	assign outs = {stats_go, ref_store, ds_clear, echo_valid};
	rcer_host H (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr,
		.pwdata);
	rcer_top #(.RX_DEPTH(8), .OUT_DEPTH(16), .PARSE_DEPTH(32)) DUT (.pclk, .presetn,
		.pce(ce), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.cmd_fault(f[0]), .cmd_fault_kind(kind), .range_fault(f[1]), .length_fault(f[2]),
		.remote_mode(~f[9]), .tx_active(tx), .rx_push(f[3]), .rx_pop(g[0]),
		.out_push(f[4]), .out_pop(g[1]), .parse_xfer(f[8]), .parse_xfer_len(pl),
		.parse_done(g[2]), .parse_done_len(pl), .data_read_fault(f[5]),
		.ds_param_change(f[6]), .ds_new_data(f[7]), .echo_valid, .echo_code, .dfilt_on,
		.ds_clear, .ref_store, .stats_go);
	task automatic report_and_stop;
		if (fails == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] v, input logic [31:0] x);
		n_tests++;
		if (v !== x)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, x, v);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		H.xfer(w, a, d, r, e, ok);
		if (!ok)
		begin
			fails++;
			report_and_stop;
		end
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		chk(n, r, x);
	endtask
	// Waits a bounded time for one output pulse; for echoes the code is compared.
	task automatic see(input int b, input int c);
		int i;
		for (i = 0; i < 6; i++)
		begin
			#1;
			if (outs[b] === 1'b1)
				break;
			@(posedge pclk);
		end
		if (i == 6)
		begin
			fails++;
			report_and_stop;
		end
		if (b == 0)
			chk("echo_code", echo_code, c);
	endtask
	task automatic ev(input logic [9:0] m, input int c);
		@(posedge pclk);
		f <= m;
		@(posedge pclk);
		f <= 10'h0;
		#1;
		chk("ds_clear", ds_clear, {31'h0, m[6]});
		if (c >= 0)
		begin
			if (ech)
				see(0, c);
			else if (q.size() < 16)
				q.push_back(c);
		end
	endtask
	task automatic faults;
		for (int k = 0; k < 8; k++)
		begin
			kind <= k[2:0];
			ev(10'h1, kc[k]);
		end
		ev(10'h2, `RCER_E201);
		ev(10'h4, `RCER_E214);
		ev(10'h200, `RCER_E301);
		tx <= 1'b0;
		ev(10'h200, -1);
		tx <= 1'b1;
		ev(10'h20, -1);
		ev(10'h40, `RCER_E705);
	endtask
	initial
	begin
		void'($urandom(32'hf97e));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdc("esr", `RCER_OFS_ESR, 32'h0);
		bus(1'b0, 8'h1c, 32'h0);
		chk("pslverr", e, 32'h1);
		faults;
		rdc("esr", `RCER_OFS_ESR, 32'h38);
		bus(1'b1, `RCER_OFS_ESR, 32'h38);
		rdc("esr", `RCER_OFS_ESR, 32'h0);
		rdc("count", `RCER_OFS_STAT, q.size());
		while (q.size() > 0)
			rdc("errq", `RCER_OFS_ERRQ, 32'h10000 | q.pop_front());
		rdc("errq", `RCER_OFS_ERRQ, 32'h0);
		bus(1'b1, `RCER_OFS_CTRL, 32'h1);
		ech = 1'b1;
		faults;
		for (int i = 0; i < 8; i++)
			ev(10'h8, -1);
		ev(10'h8, `RCER_E303);
		for (int i = 0; i < 16; i++)
			ev(10'h10, -1);
		ev(10'h10, `RCER_E304);
		pl <= 12'h14;
		ev(10'h100, -1);
		pl <= 12'h0d;
		ev(10'h100, `RCER_E305);
		pl <= 12'h0c;
		ev(10'h100, -1);
		rdc("lvl", `RCER_OFS_LVL, 32'h00200008);
		pl <= 12'h005;
		@(posedge pclk);
		g <= 3'h7;
		@(posedge pclk);
		g <= 3'h0;
		rdc("lvl", `RCER_OFS_LVL, 32'h001b0007);
		for (int i = 0; i < 8; i++)
		begin
			if (i == 6)
				ev(10'h80, -1);
			bus(1'b1, `RCER_OFS_CTRL, cw[i]);
			bus(1'b1, `RCER_OFS_CMD, cc[i]);
			see(cb[i], cx[i]);
			chk("ref_store", ref_store, {31'h0, cb[i] == 2});
			chk("stats_go", stats_go, {31'h0, cb[i] == 3});
		end
		s = 16'($urandom & 32'h7fff);
		bus(1'b1, `RCER_OFS_INTV, {s, s});
		bus(1'b1, `RCER_OFS_INTV, {s, s + 16'h1});
		see(0, `RCER_E706);
		rdc("intv", `RCER_OFS_INTV, {s, s});
		bus(1'b1, `RCER_OFS_CTRL, 32'h37);
		see(0, `RCER_E707);
		chk("dfilt_on", dfilt_on, 32'h0);
		bus(1'b1, `RCER_OFS_CTRL, 32'h35);
		repeat (2) @(posedge pclk);
		#1;
		chk("dfilt_on", dfilt_on, 32'h1);
		// A range fault while the clock enable is low must leave echo_valid and ds_clear low.
		ce <= 1'b0;
		ev(10'h2, -1);
		chk("echo_valid", echo_valid, 32'h0);
		ce <= 1'b1;
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		#1;
		chk("dfilt_on", dfilt_on, 32'h0);
		chk("echo_code", echo_code, 32'h0);
		@(posedge pclk);
		presetn <= 1'b1;
		ech = 1'b0;
		rdc("ctrl", `RCER_OFS_CTRL, 32'h0);
		// Seventeen held errors overfill the sixteen-entry queue; the last is dropped.
		for (int i = 0; i < 17; i++)
			ev(10'h2, `RCER_E201);
		rdc("stat", `RCER_OFS_STAT, 32'h310);
		bus(1'b1, `RCER_OFS_ESR, 32'h1);
		rdc("stat", `RCER_OFS_STAT, 32'h110);
		while (q.size() > 0)
			rdc("errq", `RCER_OFS_ERRQ, 32'h10000 | q.pop_front());
		rdc("stat", `RCER_OFS_STAT, 32'h0);
		report_and_stop;
	end
endmodule
`default_nettype wire
